//--- crs_alu.sv
// arithmetic unit producing result, half carry and carry for the register set
`timescale 1ns/1ps
`default_nettype none
module crs_alu
    import crs_pkg::*;
(
    crs_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    // add path with nibble sum so the bit 3 to 4 carry is visible
    always_comb begin
        low_sum = 5'h00;
        sum = 9'h000;
        bus.result = bus.opa;
        bus.half_out = 1'b0;
        bus.carry_out = 1'b0;
        unique case (bus.op)
            CRS_OP_ADD, CRS_OP_ADC: begin
                low_sum = {1'b0, bus.opa[3:0]} + {1'b0, bus.opb[3:0]}
                    + {4'h0, bus.carry_in & (bus.op == CRS_OP_ADC)};
                sum = {1'b0, bus.opa} + {1'b0, bus.opb} + {8'h00, bus.carry_in & (bus.op == CRS_OP_ADC)};
                bus.result = sum[7:0];
                bus.half_out = low_sum[HALF_BIT]; // [RULE8]
                bus.carry_out = sum[8]; // [RULE13]
            end
            CRS_OP_SUB: begin
                sum = {1'b0, bus.opa} - {1'b0, bus.opb};
                bus.result = sum[7:0];
                bus.carry_out = sum[8]; // borrow [RULE13]
            end
            CRS_OP_LOGIC: begin
                bus.result = bus.opb;
            end
            CRS_OP_SHIFT: begin
                // rotate opa left through carry; the alu does the shift itself and opb is unused
                bus.result = {bus.opa[6:0], bus.carry_in};
                bus.carry_out = bus.opa[RESULT_MSB]; // [RULE13]
            end
            CRS_OP_BTJ: begin
                // tested bit arrives in opb bit 0
                bus.carry_out = bus.opb[0]; // [RULE13]
            end
            CRS_OP_NONE: begin
                bus.result = bus.opa;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- crs_alu_if.sv
// interface carrying alu operands and flag results between alu and register set
`timescale 1ns/1ps
`default_nettype none
interface crs_alu_if;
    import crs_pkg::*;
    crs_op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic carry_in;
    logic [7:0] result;
    logic half_out;
    logic carry_out;
    modport alu (input op, opa, opb, carry_in, output result, half_out, carry_out);
    modport core (output op, opa, opb, carry_in, input result, half_out, carry_out);
endinterface
`default_nettype wire

//--- crs_core_regs.sv
// cpu core register set: accumulator, index pair, program counter, stack pointer, flags
// ==========================================================
// Overview of operation
// [RULE1] six internal registers, no address; reached only through decoder controls
// [RULE2] accumulator is eight bits, feeds and receives alu operations
// [RULE3] two eight-bit index registers for addressing or temporary data
// [RULE4] prefix opcode redirects next instruction from first to second index
// [RULE5] interrupt context save and restore never touches second index
// [RULE6] sixteen-bit program counter held as separate low and high bytes
// [RULE7] eight-bit flag register with priority field and four flags; push/pop
// [RULE8] half carry set on carry from bit 3 to 4 during add and adc
// [RULE9] branch on half carry set or clear
// [RULE10] negative flag copies result bit seven
// [RULE11] zero flag set when result is zero, else cleared
// [RULE12] branches test negative for minus/plus, zero for equal/not equal
// [RULE13] carry records overflow/borrow; also set by bit test, shift, rotate
// [RULE14] set and clear carry instructions; branch on carry set or clear
// [RULE15] bits 5,3 priority: 10 level0, 01 level1, 00 level2, 11 level3
// [RULE16] interrupt entry loads priority field from software priority registers
// [RULE17] mask, unmask, return, halt, wait and pop also change priority field
// [RULE18] sixteen-bit stack pointer resets to 01FF
// [RULE19] flag bits 7 and 6 unused and read as ones
// [RULE20] flags not affected by an instruction keep their value
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs
    import crs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // decoder: prefix and writeback
    input wire logic i_prefix_op,
    input wire logic i_instr_done,
    input wire logic i_wr_en,
    input wire crs_sel_t i_wr_sel,
    input wire logic [7:0] i_wr_data,
    // decoder: alu
    input wire crs_op_t i_alu_op,
    input wire logic [7:0] i_alu_operand,
    input wire logic i_alu_to_acc,
    // decoder: flag instructions
    input wire logic i_set_carry_op,
    input wire logic i_clear_carry_op,
    input wire logic i_mask_interrupts_op,
    input wire logic i_unmask_interrupts_op,
    input wire logic i_halt_op,
    input wire logic i_wait_for_int_op,
    input wire logic i_flag_pop,
    input wire logic i_interrupt_return_op,
    input wire logic [7:0] i_flag_pop_data,
    // program counter control
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_value,
    input wire logic i_pc_inc,
    // stack pointer control
    input wire logic i_sp_dec,
    input wire logic i_sp_inc,
    input wire logic i_sp_reset_op,
    // interrupt controller
    input wire logic i_int_entry,
    input wire logic [1:0] i_software_priority_regs,
    // branch unit
    input wire crs_br_t i_br_cond,
    output logic o_branch_taken,
    // register contents
    output logic [7:0] o_accumulator,
    output logic [7:0] o_index_first,
    output logic [7:0] o_index_second,
    output logic [7:0] o_index_sel,
    output logic [7:0] o_counter_low_byte,
    output logic [7:0] o_counter_high_byte,
    output logic [15:0] o_stack_pointer,
    output logic [7:0] o_flag_register,
    output logic [1:0] o_priority_level
);
    // ==========================================================
    // storage
    logic [7:0] acc_r;
    logic [7:0] idx_first_r;
    logic [7:0] idx_second_r;
    logic [7:0] pc_low_r;
    logic [7:0] pc_high_r;
    logic [7:0] sp_low_r;
    logic [7:0] flag_r;
    logic use_second_r;
    logic [7:0] flag_nxt;
    logic [15:0] pc_plus;

    crs_alu_if alu_bus ();

    // ==========================================================
    // alu hookup
    assign alu_bus.op = i_alu_op;
    assign alu_bus.opa = acc_r; // [RULE2]
    assign alu_bus.opb = i_alu_operand;
    assign alu_bus.carry_in = flag_r[CC_CARRY];

    crs_alu u_alu (
        .bus(alu_bus)
    );

    // ==========================================================
    // prefix latch: holds for exactly the next instruction
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            use_second_r <= 1'b0;
        end else if (i_prefix_op) begin
            use_second_r <= 1'b1; // [RULE4]
        end else if (i_instr_done) begin
            use_second_r <= 1'b0;
        end
    end

    // ==========================================================
    // accumulator: decoder writes or alu results
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            acc_r <= BYTE_ZERO;
        end else if (i_alu_to_acc && i_alu_op != CRS_OP_BTJ) begin
            acc_r <= alu_bus.result; // [RULE2]
        end else if (i_wr_en && i_wr_sel == CRS_SEL_ACC) begin
            acc_r <= i_wr_data;
        end
    end

    // index registers; interrupt context logic has no path to the second one
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            idx_first_r <= BYTE_ZERO;
            idx_second_r <= BYTE_ZERO;
        end else if (i_wr_en && i_wr_sel == CRS_SEL_INDEX) begin
            if (use_second_r) begin
                idx_second_r <= i_wr_data; // [RULE3] [RULE4] [RULE5]
            end else begin
                idx_first_r <= i_wr_data; // [RULE3]
            end
        end
    end

    // ==========================================================
    // program counter as two bytes
    assign pc_plus = {pc_high_r, pc_low_r} + 16'h0001;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pc_low_r <= PC_RESET[7:0];
            pc_high_r <= PC_RESET[15:8];
        end else if (i_pc_load) begin
            pc_low_r <= i_pc_value[7:0]; // [RULE6]
            pc_high_r <= i_pc_value[15:8];
        end else if (i_pc_inc) begin
            pc_low_r <= pc_plus[7:0]; // [RULE6]
            pc_high_r <= pc_plus[15:8];
        end
    end

    // ==========================================================
    // stack pointer: high byte fixed, low byte wraps silently
    always_ff @(posedge i_clk) begin
        if (i_srst || i_sp_reset_op) begin
            sp_low_r <= SP_RESET[7:0]; // [RULE18]
        end else if (i_wr_en && i_wr_sel == CRS_SEL_STACK_LOW) begin
            sp_low_r <= i_wr_data;
        end else if (i_sp_dec) begin
            sp_low_r <= sp_low_r - 8'h01;
        end else if (i_sp_inc) begin
            sp_low_r <= sp_low_r + 8'h01;
        end
    end

    // ==========================================================
    // flag register next value; untouched flags keep their value
    always_comb begin
        flag_nxt = flag_r; // [RULE20]
        unique case (i_alu_op)
            CRS_OP_ADD, CRS_OP_ADC: begin
                flag_nxt[CC_HALF] = alu_bus.half_out; // [RULE8]
                flag_nxt[CC_NEG] = alu_bus.result[RESULT_MSB]; // [RULE10]
                flag_nxt[CC_ZERO] = (alu_bus.result == BYTE_ZERO); // [RULE11]
                flag_nxt[CC_CARRY] = alu_bus.carry_out; // [RULE13]
            end
            CRS_OP_SUB, CRS_OP_SHIFT: begin
                flag_nxt[CC_NEG] = alu_bus.result[RESULT_MSB]; // [RULE10]
                flag_nxt[CC_ZERO] = (alu_bus.result == BYTE_ZERO); // [RULE11]
                flag_nxt[CC_CARRY] = alu_bus.carry_out; // [RULE13]
            end
            CRS_OP_LOGIC: begin
                flag_nxt[CC_NEG] = alu_bus.result[RESULT_MSB]; // [RULE10]
                flag_nxt[CC_ZERO] = (alu_bus.result == BYTE_ZERO); // [RULE11]
            end
            CRS_OP_BTJ: begin
                flag_nxt[CC_CARRY] = alu_bus.carry_out; // [RULE13]
            end
            CRS_OP_NONE: begin
                flag_nxt = flag_r;
            end
        endcase
        if (i_set_carry_op) begin
            flag_nxt[CC_CARRY] = 1'b1; // [RULE14]
        end
        if (i_clear_carry_op) begin
            flag_nxt[CC_CARRY] = 1'b0; // [RULE14]
        end
        // priority field: software instructions
        if (i_mask_interrupts_op) begin
            {flag_nxt[CC_PRIO_HI], flag_nxt[CC_PRIO_LO]} = PRIO_LEVEL3; // [RULE17]
        end
        if (i_unmask_interrupts_op || i_halt_op || i_wait_for_int_op) begin
            {flag_nxt[CC_PRIO_HI], flag_nxt[CC_PRIO_LO]} = PRIO_LEVEL0; // [RULE17]
        end
        // whole-register restore from stack; return is a pop of the flags too
        if (i_flag_pop || i_interrupt_return_op) begin
            flag_nxt = i_flag_pop_data; // [RULE7] [RULE17]
        end
        // hardware interrupt entry wins over any same-cycle instruction effect on the priority field
        if (i_int_entry) begin
            {flag_nxt[CC_PRIO_HI], flag_nxt[CC_PRIO_LO]} = i_software_priority_regs; // [RULE16]
        end
        flag_nxt = flag_nxt | CC_ONES_MASK; // [RULE19]
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flag_r <= CC_RESET; // [RULE15] level 3 after reset
        end else begin
            flag_r <= flag_nxt; // [RULE7]
        end
    end

    // ==========================================================
    // branch evaluation, combinational for the sequencer
    always_comb begin
        unique case (i_br_cond)
            CRS_BR_HALF: o_branch_taken = flag_r[CC_HALF]; // [RULE9]
            CRS_BR_NO_HALF: o_branch_taken = ~flag_r[CC_HALF]; // [RULE9]
            CRS_BR_MINUS: o_branch_taken = flag_r[CC_NEG]; // [RULE12]
            CRS_BR_PLUS: o_branch_taken = ~flag_r[CC_NEG]; // [RULE12]
            CRS_BR_EQUAL: o_branch_taken = flag_r[CC_ZERO]; // [RULE12]
            CRS_BR_NOT_EQUAL: o_branch_taken = ~flag_r[CC_ZERO]; // [RULE12]
            CRS_BR_CARRY: o_branch_taken = flag_r[CC_CARRY]; // [RULE14]
            CRS_BR_NO_CARRY: o_branch_taken = ~flag_r[CC_CARRY]; // [RULE14]
            CRS_BR_ALWAYS: o_branch_taken = 1'b1;
            default: o_branch_taken = 1'b0; // unused enum codes
        endcase
    end

    // ==========================================================
    // register views for the datapath; no address map exists
    assign o_accumulator = acc_r; // [RULE1]
    assign o_index_first = idx_first_r;
    assign o_index_second = idx_second_r;
    assign o_index_sel = use_second_r ? idx_second_r : idx_first_r; // [RULE4]
    assign o_counter_low_byte = pc_low_r;
    assign o_counter_high_byte = pc_high_r;
    assign o_stack_pointer = {SP_HIGH_FIXED, sp_low_r}; // [RULE18]
    assign o_flag_register = flag_r;
    assign o_priority_level = {flag_r[CC_PRIO_HI], flag_r[CC_PRIO_LO]}; // [RULE15]
endmodule
`default_nettype wire

//--- crs_core_regs_asserts.sv
// concurrent checks on the ports of the core register set
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_asserts
    import crs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // watched controls
    input wire crs_op_t i_alu_op,
    input wire logic [7:0] i_alu_operand,
    input wire logic i_alu_to_acc,
    input wire logic i_set_carry_op,
    input wire logic i_clear_carry_op,
    input wire logic i_unmask_interrupts_op,
    input wire logic i_mask_interrupts_op,
    input wire logic i_halt_op,
    input wire logic i_wait_for_int_op,
    input wire logic i_flag_pop,
    input wire logic i_interrupt_return_op,
    input wire logic i_int_entry,
    input wire logic [1:0] i_software_priority_regs,
    input wire logic i_wr_en,
    input wire crs_br_t i_br_cond,
    // watched results
    input wire logic o_branch_taken,
    input wire logic [7:0] o_accumulator,
    input wire logic [7:0] o_index_second,
    input wire logic [15:0] o_stack_pointer,
    input wire logic [7:0] o_flag_register,
    input wire logic [1:0] o_priority_level
);
    // ==========================================
    // helpers
    logic [4:0] low_sum;
    logic br_exp;
    logic quiet;
    // a pop or return overwrites every flag, so flag checks exclude them
    assign quiet = !i_flag_pop && !i_interrupt_return_op;
    assign low_sum = {1'b0, o_accumulator[3:0]} + {1'b0, i_alu_operand[3:0]};
    // expected branch decision from the current flags
    always_comb begin
        case (i_br_cond)
            CRS_BR_HALF: br_exp = o_flag_register[CC_HALF];
            CRS_BR_NO_HALF: br_exp = !o_flag_register[CC_HALF];
            CRS_BR_MINUS: br_exp = o_flag_register[CC_NEG];
            CRS_BR_PLUS: br_exp = !o_flag_register[CC_NEG];
            CRS_BR_EQUAL: br_exp = o_flag_register[CC_ZERO];
            CRS_BR_NOT_EQUAL: br_exp = !o_flag_register[CC_ZERO];
            CRS_BR_CARRY: br_exp = o_flag_register[CC_CARRY];
            CRS_BR_NO_CARRY: br_exp = !o_flag_register[CC_CARRY];
            default: br_exp = 1'b1;
        endcase
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ==========================================
    // properties
    property p_rst;
        $fell(i_srst) |-> o_flag_register == CC_RESET && o_stack_pointer == SP_RESET;
    endproperty
    property p_ones;
        o_flag_register[7:6] == 2'h3;
    endproperty
    property p_setc;
        quiet && i_set_carry_op && !i_clear_carry_op && i_alu_op == CRS_OP_NONE |=> o_flag_register[CC_CARRY];
    endproperty
    property p_clrc;
        quiet && i_clear_carry_op && i_alu_op == CRS_OP_NONE |=> !o_flag_register[CC_CARRY];
    endproperty
    property p_half;
        quiet && i_alu_op == CRS_OP_ADD |=> o_flag_register[CC_HALF] == $past(low_sum[4]);
    endproperty
    property p_nz;
        quiet && i_alu_to_acc && i_alu_op inside {CRS_OP_ADD, CRS_OP_ADC, CRS_OP_SUB, CRS_OP_LOGIC}
            |=> o_flag_register[CC_NEG] == o_accumulator[7] && o_flag_register[CC_ZERO] == (o_accumulator == 8'h00);
    endproperty
    property p_entry;
        i_int_entry |=> o_priority_level == $past(i_software_priority_regs);
    endproperty
    property p_unmask;
        quiet && !i_int_entry && (i_unmask_interrupts_op || i_halt_op || i_wait_for_int_op)
            |=> o_priority_level == PRIO_LEVEL0;
    endproperty
    // mask alone must land on level 3; unmask, halt and wait outrank it
    property p_mask;
        quiet && !i_int_entry && i_mask_interrupts_op && !i_unmask_interrupts_op && !i_halt_op && !i_wait_for_int_op
            |=> o_priority_level == PRIO_LEVEL3;
    endproperty
    property p_yidx;
        i_int_entry && !i_wr_en |=> $stable(o_index_second);
    endproperty
    property p_br;
        o_branch_taken == br_exp;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_ones: assert property (p_ones) else $error("flag bits 7:6 not ones");
    a_setc: assert property (p_setc) else $error("carry not set");
    a_clrc: assert property (p_clrc) else $error("carry not cleared");
    a_half: assert property (p_half) else $error("half carry wrong");
    a_nz: assert property (p_nz) else $error("negative or zero wrong");
    a_entry: assert property (p_entry) else $error("entry priority wrong");
    a_unmask: assert property (p_unmask) else $error("unmask level wrong");
    a_mask: assert property (p_mask) else $error("mask level wrong");
    a_yidx: assert property (p_yidx) else $error("second index disturbed");
    a_br: assert property (p_br) else $error("branch decision wrong");
    c_half: cover property (i_alu_op == CRS_OP_ADD ##1 o_flag_register[CC_HALF]);
    c_entry: cover property (i_int_entry);
    c_pop: cover property (i_flag_pop);
endmodule
bind crs_core_regs crs_core_regs_asserts u_asserts (
    .i_clk(i_clk), .i_srst(i_srst), .i_alu_op(i_alu_op), .i_alu_operand(i_alu_operand),
    .i_alu_to_acc(i_alu_to_acc), .i_set_carry_op(i_set_carry_op), .i_clear_carry_op(i_clear_carry_op),
    .i_unmask_interrupts_op(i_unmask_interrupts_op), .i_flag_pop(i_flag_pop),
    .i_mask_interrupts_op(i_mask_interrupts_op), .i_halt_op(i_halt_op), .i_wait_for_int_op(i_wait_for_int_op),
    .i_interrupt_return_op(i_interrupt_return_op), .i_int_entry(i_int_entry),
    .i_software_priority_regs(i_software_priority_regs), .i_wr_en(i_wr_en), .i_br_cond(i_br_cond),
    .o_branch_taken(o_branch_taken), .o_accumulator(o_accumulator), .o_index_second(o_index_second),
    .o_stack_pointer(o_stack_pointer), .o_flag_register(o_flag_register), .o_priority_level(o_priority_level)
);
`default_nettype wire

//--- crs_core_regs_test.sv
// self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_test;
    import crs_pkg::*;
    // ==========================================
    // pulse bit positions
    localparam int PRE = 0, DONE = 1, WR = 2, TOACC = 3, SETC = 4, CLRC = 5, MASK = 6, UNMASK = 7;
    localparam int POP = 10, INTERRUPT_RETURN_OP = 11, PCLD = 12, PCINC = 13, SPD = 14, SPI = 15, SPR = 16, CFG = 17, REQ = 18;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [18:0] pl = '0;
    crs_op_t op = CRS_OP_NONE;
    crs_sel_t sel = CRS_SEL_ACC;
    crs_br_t cond = CRS_BR_ALWAYS;
    logic [15:0] dd = 16'h0000;
    logic entry, taken;
    logic [1:0] prio, lvl;
    logic [7:0] acc, ix1, ix2, ixs, counter_low_byte, counter_high_byte, cc;
    logic [15:0] sp;
    int n_errors = 0;
    int total_checks = 0;
    crs_core_regs u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_prefix_op(pl[PRE]), .i_instr_done(pl[DONE]),
        .i_wr_en(pl[WR]), .i_wr_sel(sel), .i_wr_data(dd[7:0]), .i_alu_op(op), .i_alu_operand(dd[7:0]),
        .i_alu_to_acc(pl[TOACC]), .i_set_carry_op(pl[SETC]), .i_clear_carry_op(pl[CLRC]),
        .i_mask_interrupts_op(pl[MASK]), .i_unmask_interrupts_op(pl[UNMASK]), .i_halt_op(pl[8]),
        .i_wait_for_int_op(pl[9]), .i_flag_pop(pl[POP]), .i_interrupt_return_op(pl[INTERRUPT_RETURN_OP]),
        .i_flag_pop_data(dd[7:0]), .i_pc_load(pl[PCLD]), .i_pc_value(dd), .i_pc_inc(pl[PCINC]),
        .i_sp_dec(pl[SPD]), .i_sp_inc(pl[SPI]), .i_sp_reset_op(pl[SPR]), .i_int_entry(entry),
        .i_software_priority_regs(prio), .i_br_cond(cond), .o_branch_taken(taken), .o_accumulator(acc),
        .o_index_first(ix1), .o_index_second(ix2), .o_index_sel(ixs), .o_counter_low_byte(counter_low_byte),
        .o_counter_high_byte(counter_high_byte), .o_stack_pointer(sp), .o_flag_register(cc), .o_priority_level(lvl));
    crs_int_model u_int (.i_clk(i_clk), .i_srst(i_srst), .i_cfg_we(pl[CFG]), .i_src(dd[9:8]),
        .i_cfg(dd[1:0]), .i_req(pl[REQ]), .o_int_entry(entry), .o_software_priority_regs(prio));
    // 20 MHz clock
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    // ==========================================
    // tasks: one decoder cycle, compares, verdict
    task automatic cyc(input logic [18:0] p, input crs_op_t o = CRS_OP_NONE,
                       input crs_sel_t s = CRS_SEL_ACC, input logic [15:0] d = 16'h0000);
        @(posedge i_clk);
        pl <= p;
        op <= o;
        sel <= s;
        dd <= d;
        @(posedge i_clk);
        pl <= '0;
        op <= CRS_OP_NONE;
        #1;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // walk every branch condition against a mask of expected outcomes
    task automatic brall(input logic [8:0] m);
        for (int i = 0; i < 9; i++) begin
            @(posedge i_clk);
            cond <= crs_br_t'(i);
            #1;
            chk8({7'h00, taken}, {7'h00, m[i]});
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a hang is cut short well past the expected run length
    initial begin
        repeat (2000) @(posedge i_clk);
        n_errors++;
        test_done();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        chk8(cc, CC_RESET);
        chk16(sp, SP_RESET);
        chk16({counter_high_byte, counter_low_byte}, PC_RESET);
        cyc(19'h1 << WR, CRS_OP_NONE, CRS_SEL_ACC, 16'h0008);
        cyc(19'h1 << TOACC, CRS_OP_ADD, CRS_SEL_ACC, 16'h0008);
        chk8(acc, 8'h10);
        chk8(cc, 8'hF8);
        cyc(19'h1 << TOACC, CRS_OP_ADD, CRS_SEL_ACC, 16'h00F0);
        chk8(acc, 8'h00);
        chk8(cc, 8'hEB);
        cyc(19'h1 << TOACC, CRS_OP_LOGIC, CRS_SEL_ACC, 16'h0080);
        chk8(cc, 8'hED);
        cyc(19'h0, CRS_OP_BTJ);
        chk8(cc, 8'hEC);
        cyc(19'h1 << SETC);
        chk8(cc, 8'hED);
        cyc(19'h1 << CLRC);
        chk8(cc, 8'hEC);
        for (int k = UNMASK; k <= 9; k++) begin
            cyc(19'h1 << MASK);
            chk8({6'h00, lvl}, {6'h00, PRIO_LEVEL3});
            cyc(19'h1 << k);
            chk8(cc, 8'hE4);
        end
        cyc(19'h1 << PRE);
        cyc(19'h1 << WR, CRS_OP_NONE, CRS_SEL_INDEX, 16'h005A);
        chk8(ixs, 8'h5A);
        cyc(19'h1 << DONE);
        cyc(19'h1 << WR, CRS_OP_NONE, CRS_SEL_INDEX, 16'h0033);
        chk8(ix2, 8'h5A);
        chk8(ixs, 8'h33);
        chk8(ix1, 8'h33);
        cyc(19'h1 << CFG, CRS_OP_NONE, CRS_SEL_ACC, 16'h0201);
        cyc(19'h1 << REQ, CRS_OP_NONE, CRS_SEL_ACC, 16'h0200);
        @(posedge i_clk);
        #1;
        chk8(cc, 8'hCC);
        chk8(ix2, 8'h5A);
        cyc(19'h1 << POP, CRS_OP_NONE, CRS_SEL_ACC, 16'h0000);
        chk8(cc, 8'hC0);
        brall(9'h1AA);
        cyc(19'h1 << INTERRUPT_RETURN_OP, CRS_OP_NONE, CRS_SEL_ACC, 16'h0010);
        chk8(cc, 8'hD0);
        brall(9'h1A9);
        cyc(19'h1 << PCLD, CRS_OP_NONE, CRS_SEL_ACC, 16'h12FF);
        cyc(19'h1 << PCINC);
        chk16({counter_high_byte, counter_low_byte}, 16'h1300);
        cyc(19'h1 << SPD);
        chk16(sp, 16'h01FE);
        cyc(19'h1 << WR, CRS_OP_NONE, CRS_SEL_STACK_LOW, 16'h0040);
        cyc(19'h1 << SPI);
        chk16(sp, 16'h0141);
        cyc(19'h1 << SPR);
        chk16(sp, SP_RESET);
        // subtract with borrow, add with carry in, rotate through carry
        cyc(19'h1 << TOACC, CRS_OP_SUB, CRS_SEL_ACC, 16'h0081);
        chk8(acc, 8'hFF);
        chk8(cc, 8'hD5);
        brall(9'h165);
        cyc(19'h1 << TOACC, CRS_OP_ADC, CRS_SEL_ACC, 16'h0000);
        chk8(acc, 8'h00);
        chk8(cc, 8'hD3);
        brall(9'h159);
        cyc(19'h1 << TOACC, CRS_OP_SHIFT, CRS_SEL_ACC, 16'h0000);
        chk8(acc, 8'h01);
        chk8(cc, 8'hD0);
        @(posedge i_clk);
        i_srst <= 1'b1;
        @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        chk8(acc, 8'h00);
        chk8(cc, CC_RESET);
        cyc(19'h1 << SETC);
        chk8(cc, 8'hE9);
        test_done();
    end
endmodule
`default_nettype wire

//--- crs_int_model.sv
// interrupt controller model holding a priority setting per source
`timescale 1ns/1ps
`default_nettype none
module crs_int_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // setting and request
    input wire logic i_cfg_we,
    input wire logic [1:0] i_src,
    input wire logic [1:0] i_cfg,
    input wire logic i_req,
    // to the register set
    output logic o_int_entry,
    output logic [1:0] o_software_priority_regs
);
    // ==========================================
    // settings default to level 3 so a stray request cannot unmask
    logic [1:0] spr_r [4];
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            spr_r <= '{default: 2'h3};
        end else if (i_cfg_we) begin
            spr_r[i_src] <= i_cfg;
        end
    end
    // entry registered one cycle after each request cycle, carrying the source setting
    always_ff @(posedge i_clk) begin
        o_int_entry <= i_req && !i_srst;
        o_software_priority_regs <= spr_r[i_src];
    end
endmodule
`default_nettype wire

//--- crs_pkg.sv
// package of constants and types for the cpu core register set
package crs_pkg;
    // condition code bit positions
    localparam int CC_CARRY = 0;
    localparam int CC_ZERO = 1;
    localparam int CC_NEG = 2;
    localparam int CC_PRIO_LO = 3;
    localparam int CC_HALF = 4;
    localparam int CC_PRIO_HI = 5;
    localparam int RESULT_MSB = 7;
    localparam int HALF_BIT = 4;
    // reset values
    localparam logic [7:0] CC_RESET = 8'hE8;
    localparam logic [7:0] CC_ONES_MASK = 8'hC0;
    localparam logic [15:0] SP_RESET = 16'h01FF;
    localparam logic [7:0] SP_HIGH_FIXED = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // priority field codes {hi,lo}
    localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
    localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
    localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
    localparam logic [1:0] PRIO_LEVEL3 = 2'h3;

    // alu operation classes issued by the decoder
    typedef enum logic [2:0] {
        CRS_OP_NONE,
        CRS_OP_ADD,
        CRS_OP_ADC,
        CRS_OP_SUB,
        CRS_OP_LOGIC,
        CRS_OP_SHIFT,
        CRS_OP_BTJ
    } crs_op_t;

    // branch conditions
    typedef enum logic [3:0] {
        CRS_BR_HALF,
        CRS_BR_NO_HALF,
        CRS_BR_MINUS,
        CRS_BR_PLUS,
        CRS_BR_EQUAL,
        CRS_BR_NOT_EQUAL,
        CRS_BR_CARRY,
        CRS_BR_NO_CARRY,
        CRS_BR_ALWAYS
    } crs_br_t;

    // register select for the writeback port
    typedef enum logic [1:0] {
        CRS_SEL_ACC,
        CRS_SEL_INDEX,
        CRS_SEL_STACK_LOW
    } crs_sel_t;
endpackage
